// File: mitp_pkg.sv
// Package: register map, field layout and codes of the interrupt/tick block
package mitp_pkg;
   // ---------------------------------------------------------------
   // Bus and register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_IRQ_CTRL = 8'h00; // Enables, pull, edge
   localparam logic [7:0] OFS_IRQ_FLAG = 8'h04; // Request flags, W1C
   localparam logic [7:0] OFS_TMR_IRQ = 8'h08; // Timer flags/enables
   localparam logic [7:0] OFS_TICK_CTRL0 = 8'h0C;
   localparam logic [7:0] OFS_TICK_CTRL1 = 8'h10;
   localparam logic [7:0] OFS_PSC_CTRL = 8'h14; // prescaler_ctrl_reg
   localparam logic [7:0] OFS_STATUS = 8'h18; // Read-only state
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int NSRC = 6;
   localparam int CTRL_GIE = 0;
   localparam int CTRL_EN = 1;
   localparam int CTRL_PULL = 7;
   localparam int CTRL_EDGE = 8;
   localparam int TMR_AF = 0;
   localparam int TMR_PF = 2;
   localparam int TMR_AE = 4;
   localparam int TMR_PE = 6;
   localparam int TBC_ON = 7;
   localparam int PSC_EN = 2;
   localparam int PSC_SUB = 1;
   localparam int STAT_REQ = 0;
   localparam int STAT_SRC = 1;
   localparam int STAT_STK = 4;
   // ---------------------------------------------------------------
   // Reset values and codes
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_TBC = 8'h00;
   localparam logic [2:0] RST_PSC = 3'h0;
   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [1:0] SEL_SYS = 2'h0;
   localparam logic [1:0] SEL_DIV4 = 2'h1;
   localparam logic [1:0] DIV4_LAST = 2'h3;
   // Sources in falling priority
   typedef enum logic [2:0] {
      SRC_EXT, SRC_GRP0, SRC_GRP1, SRC_TICK0, SRC_TICK1, SRC_CONV
   } mitp_src_e;
   // Vector address of each source
   function automatic logic [7:0] mitp_vec(input mitp_src_e s);
      case (s)
         SRC_EXT: mitp_vec = 8'h04;
         SRC_GRP0: mitp_vec = 8'h08;
         SRC_GRP1: mitp_vec = 8'h0C;
         SRC_TICK0: mitp_vec = 8'h10;
         SRC_TICK1: mitp_vec = 8'h14;
         default: mitp_vec = 8'h1C;
      endcase
   endfunction : mitp_vec
endpackage : mitp_pkg

// File: mitp_sync.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ns
module mitp_sync #(
   parameter int W = 2
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [W-1:0] s1; // First stage, read only by s2
      logic [W-1:0] s2; // Safe stage
   } mitp_sync_s;
   mitp_sync_s q, d;
   // Shift the pins through both stages
   always_comb begin
      d.s1 = async_in;
      d.s2 = q.s1;
   end
   // Register the copy
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign sync_out = q.s2;
endmodule : mitp_sync

// File: mitp_tick.sv
// Time-base divider: counts prescaler steps, pulses on overflow
`timescale 1ns/1ns
module mitp_tick #(
   parameter int CNT_W = 16,
   parameter int TB_BASE = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic step,
   input wire logic tick_on,
   input wire logic [2:0] ratio,
   output logic ovf
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [CNT_W-1:0] cnt; // Steps seen so far
      logic ovf; // Overflow pulse
   } mitp_tick_s;
   mitp_tick_s q, d;
   logic [CNT_W-1:0] lim; // Last count of the selected period
   // Period is 2^(base+ratio) prescaler steps
   always_comb begin
      lim = CNT_W'((32'h1 << (TB_BASE + int'(ratio))) - 32'h1);
      d = q;
      d.ovf = 1'b0;
      if (!tick_on) begin
         // Stopped divider restarts from zero
         d.cnt = '0;
      end else if (step) begin
         if (q.cnt == lim) begin
            d.cnt = '0;
            d.ovf = 1'b1;
         end else begin
            d.cnt = q.cnt + 1'b1;
         end
      end
   end
   // Register the copy
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign ovf = q.ovf;
   // A stopped divider never overflows
   AST_TICK_OFF: assert property (
      @(posedge core_clk) disable iff (rst)
      !tick_on |=> !ovf) else $error("tick overflow while off");
endmodule : mitp_tick

// File: mitp_top.sv
// Interrupt request, priority and time-base prescaler logic
`timescale 1ns/1ns
// Operation
// - Selected pin edge sets external flag
// - External vectors need global and own enable
// - No vector call while stack full
// - External service clears flag and global enable
// - Pin pull-high stays valid as interrupt
// - Edge select: rising, falling, both, off
// - Two group interrupts built from timers
// - Enabled member request sets its group flag
// - Group service clears only group, global
// - Conversion done sets converter flag
// - Converter vectors with enables, self-clears
// - Each timer: match A and P sources
// - Timer needs global, own, group enables
// - Divider overflow sets tick flag, serviced
// - Tick ratio selects longer periods
// - Source select: sys, sys/4, sub clock
// - Enable bit gates prescaler clock
// - Prescaler bits seven to three read zero
// - Global disable blocks vectors, flags record
// - New flag wakes device from sleep
module mitp_top
   import mitp_pkg::*;
#(
   parameter int TICK_CNT_W = 16,
   parameter int TB_BASE = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [mitp_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_irq_pin,
   input wire logic slow_clk,
   input wire logic [1:0] tmr_match_a,
   input wire logic [1:0] tmr_match_p,
   input wire logic conv_done,
   input wire logic stack_full,
   input wire logic irq_ack,
   input wire logic sleep_mode,
   output logic irq_req,
   output logic [7:0] irq_vector,
   output logic wake_pulse,
   output logic pin_pullup_en,
   output logic prescaler_clk
);
   import mitp_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic gie; // global_irq_en
      logic [NSRC-1:0] en; // Per-source enables, priority order
      logic pull; // Pull-high select of the pin
      logic [1:0] edge_sel; // edge_select_reg
      logic [NSRC-1:0] flg; // Request flags, priority order
      logic [1:0] tm_af; // Timer match A flags
      logic [1:0] tm_pf; // Timer match P flags
      logic [1:0] tm_ae; // Timer match A enables
      logic [1:0] tm_pe; // Timer match P enables
      logic [7:0] tbc0; // tick_ctrl_reg of divider 0
      logic [7:0] tbc1; // tick_ctrl_reg of divider 1
      logic [2:0] psc; // prescaler_ctrl_reg
      logic [1:0] div4; // System clock quarter counter
      logic pin_prev; // Last synchronised pin level
      logic sub_prev; // Last synchronised sub clock level
      logic psc_pulse; // prescaler_clk enable pulse
      logic req; // Vector request to the core
      mitp_src_e src; // Source behind the request
      logic [7:0] vec; // Vector address
      logic wake; // Wake pulse
      logic pready; // APB answer
      logic [31:0] prdata; // APB read data
      logic pslverr; // APB error
   } mitp_top_s;
   mitp_top_s q, d;

   // ---------------------------------------------------------------
   // Pin synchronisers and tick dividers
   // ---------------------------------------------------------------
   logic [1:0] pin_s; // [0] pin, [1] sub clock
   logic [1:0] tick_ovf; // Divider overflow pulses
   logic [7:0] tbc [2]; // Tick controls as an array

   mitp_sync #(.W(2)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in({slow_clk, ext_irq_pin}),
      .sync_out(pin_s)
   );

   assign tbc[0] = q.tbc0;
   assign tbc[1] = q.tbc1;

   // One divider per time-base interrupt
   for (genvar g = 0; g < 2; g++) begin : g_tick
      mitp_tick #(.CNT_W(TICK_CNT_W), .TB_BASE(TB_BASE)) u_tick (
         .core_clk(core_clk),
         .rst(rst),
         .step(q.psc_pulse),
         .tick_on(tbc[g][TBC_ON]),
         .ratio(tbc[g][2:0]),
         .ovf(tick_ovf[g])
      );
   end

   // ---------------------------------------------------------------
   // Event decode
   // ---------------------------------------------------------------
   logic pin_rise; // Rising edge on the pin
   logic pin_fall; // Falling edge on the pin
   logic sub_rise; // Rising edge of the sub clock
   logic ext_set; // Selected edge seen
   logic [1:0] grp_set; // Enabled member raised its flag
   logic [NSRC-1:0] set; // All flag set events
   logic acc; // APB access phase
   logic hit; // Address maps to a register
   logic done; // Completing APB edge
   logic [31:0] rd; // Read mux

   // Edges come from the second stage only
   always_comb begin
      pin_rise = pin_s[0] & ~q.pin_prev;
      pin_fall = ~pin_s[0] & q.pin_prev;
      sub_rise = pin_s[1] & ~q.sub_prev;
      // Off code sets no flag from either pin edge; the pull-high select still applies
      unique case (q.edge_sel)
         EDGE_RISE: ext_set = pin_rise;
         EDGE_FALL: ext_set = pin_fall;
         EDGE_BOTH: ext_set = pin_rise | pin_fall;
         default: ext_set = 1'b0;
      endcase
      // A member with its own enable clear stays out of the group
      grp_set = (tmr_match_a & q.tm_ae) | (tmr_match_p & q.tm_pe);
      set = {conv_done, tick_ovf, grp_set, ext_set};
   end

   // ---------------------------------------------------------------
   // APB decode and read mux
   // ---------------------------------------------------------------
   always_comb begin
      acc = psel & penable;
      done = acc & q.pready;
      hit = 1'b1;
      rd = '0;
      unique case (paddr)
         OFS_IRQ_CTRL: begin
            rd[CTRL_GIE] = q.gie;
            rd[CTRL_EN +: NSRC] = q.en;
            rd[CTRL_PULL] = q.pull;
            rd[CTRL_EDGE +: 2] = q.edge_sel;
         end
         OFS_IRQ_FLAG: rd[NSRC-1:0] = q.flg;
         OFS_TMR_IRQ: begin
            rd[TMR_AF +: 2] = q.tm_af;
            rd[TMR_PF +: 2] = q.tm_pf;
            rd[TMR_AE +: 2] = q.tm_ae;
            rd[TMR_PE +: 2] = q.tm_pe;
         end
         OFS_TICK_CTRL0: rd[7:0] = q.tbc0;
         OFS_TICK_CTRL1: rd[7:0] = q.tbc1;
         OFS_PSC_CTRL: rd[2:0] = q.psc;
         OFS_STATUS: begin
            rd[STAT_REQ] = q.req;
            rd[STAT_SRC +: 3] = q.src;
            rd[STAT_STK] = stack_full;
         end
         default: hit = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      d.pin_prev = pin_s[0];
      d.sub_prev = pin_s[1];
      // One wait state: answer on the second access cycle
      d.pready = acc & ~q.pready;
      d.prdata = '0;
      d.pslverr = 1'b0;
      if (acc && !q.pready) begin
         d.prdata = pwrite ? '0 : rd;
         d.pslverr = ~hit;
      end
      // Writes land on the edge that completes the transfer
      if (done && pwrite && hit) begin
         unique case (paddr)
            OFS_IRQ_CTRL: begin
               d.gie = pwdata[CTRL_GIE];
               d.en = pwdata[CTRL_EN +: NSRC];
               d.pull = pwdata[CTRL_PULL];
               d.edge_sel = pwdata[CTRL_EDGE +: 2];
            end
            OFS_IRQ_FLAG: d.flg = q.flg & ~pwdata[NSRC-1:0];
            OFS_TMR_IRQ: begin
               // Member flags only clear by software
               d.tm_af = q.tm_af & ~pwdata[TMR_AF +: 2];
               d.tm_pf = q.tm_pf & ~pwdata[TMR_PF +: 2];
               d.tm_ae = pwdata[TMR_AE +: 2];
               d.tm_pe = pwdata[TMR_PE +: 2];
            end
            OFS_TICK_CTRL0: d.tbc0 = pwdata[7:0];
            OFS_TICK_CTRL1: d.tbc1 = pwdata[7:0];
            OFS_PSC_CTRL: d.psc = pwdata[2:0];
            default: d.psc = q.psc;
         endcase
      end
      // Service: own flag and global enable drop, members stay
      if (irq_ack && q.req) begin
         d.flg[q.src] = 1'b0;
         d.gie = 1'b0;
      end
      // Hardware sets win over any clear in the same cycle
      d.flg = d.flg | set;
      d.tm_af = d.tm_af | tmr_match_a;
      d.tm_pf = d.tm_pf | tmr_match_p;
      // Only a newly raised flag wakes; one already set does not
      d.wake = sleep_mode & |(d.flg & ~q.flg);
      // Lowest index pending wins
      d.req = 1'b0;
      d.src = SRC_EXT;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (d.flg[i] && d.en[i]) begin
            d.req = 1'b1;
            d.src = mitp_src_e'(i[2:0]);
         end
      end
      // Global enable and free stack space gate every vector
      d.req = d.req & d.gie & ~stack_full;
      d.vec = mitp_vec(d.src);
      // Prescaler: quarter counter runs only while enabled
      d.div4 = q.psc[PSC_EN] ? q.div4 + 1'b1 : '0;
      if (!q.psc[PSC_EN]) begin
         d.psc_pulse = 1'b0;
      end else if (q.psc[PSC_SUB]) begin
         d.psc_pulse = sub_rise;
      end else if (q.psc[1:0] == SEL_DIV4) begin
         d.psc_pulse = (q.div4 == DIV4_LAST);
      end else begin
         d.psc_pulse = 1'b1;
      end
   end

   // Register the copy; all control starts cleared
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.tbc0 <= RST_TBC;
         q.tbc1 <= RST_TBC;
         q.psc <= RST_PSC;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all from flip-flops
   // ---------------------------------------------------------------
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign irq_req = q.req;
   assign irq_vector = q.vec;
   assign wake_pulse = q.wake;
   assign pin_pullup_en = q.pull;
   assign prescaler_clk = q.psc_pulse;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   AST_REQ_NEEDS_GIE: assert property (
      q.req |-> q.gie && q.en[q.src] && q.flg[q.src]
   ) else $error("request without enables");
   AST_STACK_FULL: assert property (
      stack_full |=> !q.req
   ) else $error("request while stack full");
   AST_SERVICE_CLEAR: assert property (
      irq_ack && q.req && !set[q.src] |=> !q.gie && !q.flg[$past(q.src)]
   ) else $error("service did not clear");
   AST_GIE_OFF: assert property (
      !q.gie && !(done && pwrite && paddr == OFS_IRQ_CTRL) |=> !q.req
   ) else $error("request with global off");
   AST_EDGE_RISE: assert property (
      q.edge_sel == EDGE_RISE && pin_rise |=> q.flg[SRC_EXT]
   ) else $error("rising edge missed");
   AST_EDGE_FALL: assert property (
      q.edge_sel == EDGE_FALL && pin_fall |=> q.flg[SRC_EXT]
   ) else $error("falling edge missed");
   // Watches the flag itself, so a path around the decoder shows up
   AST_EDGE_OFF: assert property (
      q.edge_sel == EDGE_OFF && !q.flg[SRC_EXT] |=> !q.flg[SRC_EXT]
   ) else $error("edge seen while off");
   AST_GROUP_SET: assert property (
      tmr_match_a[0] && q.tm_ae[0] |=> q.flg[SRC_GRP0] && q.tm_af[0]
   ) else $error("group flag missed");
   AST_MEMBER_KEEP: assert property (
      irq_ack && q.req && q.src == SRC_GRP1 && q.tm_pf[1]
      && !(done && pwrite) |=> q.tm_pf[1]
   ) else $error("member flag cleared");
   AST_CONV_SET: assert property (
      conv_done |=> q.flg[SRC_CONV]
   ) else $error("conversion flag missed");
   AST_PRIORITY: assert property (
      q.req && q.flg[SRC_EXT] && q.en[SRC_EXT] |-> q.src == SRC_EXT
      && q.vec == 8'h04
   ) else $error("priority broken");
   AST_PSC_SYS: assert property (
      q.psc == {1'b1, SEL_SYS} |=> q.psc_pulse
   ) else $error("system step missing");
   AST_PSC_DIV4: assert property (
      q.psc == {1'b1, SEL_DIV4} && q.div4 != DIV4_LAST |=> !q.psc_pulse
   ) else $error("quarter step too early");
   AST_PSC_GATE: assert property (
      !q.psc[PSC_EN] |=> !q.psc_pulse
   ) else $error("prescaler not gated");
   AST_PSC_READ: assert property (
      acc && !q.pready && !pwrite && paddr == OFS_PSC_CTRL
      |=> prdata[31:3] == '0 && pready
   ) else $error("upper bits not zero");
   AST_TICK_SET: assert property (
      tick_ovf[1] |=> q.flg[SRC_TICK1]
   ) else $error("tick flag missed");
   AST_WAKE_NEW: assert property (
      sleep_mode && !q.flg[SRC_TICK1] && tick_ovf[1] |=> wake_pulse
   ) else $error("wake pulse missed");
endmodule : mitp_top

// File: mitp_core_model.sv
// Processor core model: takes vector calls that the block requests
`timescale 1ns/1ns
module mitp_core_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic irq_req,
   input wire logic [7:0] irq_vector,
   input wire logic auto_ack,
   input wire logic [1:0] lag,
   output logic irq_ack,
   output logic [7:0] last_vec
);
   // ---------------------------------------------------------------
   // Call sequencer
   // ---------------------------------------------------------------
   logic [1:0] wait_q; // Cycles spent before taking the call
   // Ack is one cycle wide and never repeated while it is still up,
   // so one request is never taken twice; lag makes the core slow
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_ack <= 1'b0;
         last_vec <= 8'h00;
         wait_q <= 2'h0;
      end else begin
         irq_ack <= 1'b0;
         if (auto_ack && irq_req && !irq_ack) begin
            if (wait_q == lag) begin
               // Take the call and note where it went
               irq_ack <= 1'b1;
               last_vec <= irq_vector;
               wait_q <= 2'h0;
            end else begin
               wait_q <= wait_q + 2'h1;
            end
         end else begin
            wait_q <= 2'h0;
         end
      end
   end
endmodule : mitp_core_model

// File: testbench.sv
// Self-checking bench for the interrupt and tick prescaler block
`timescale 1ns/1ns
module testbench;
   import mitp_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------------------------
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic ext_irq_pin = 1'b0, slow_clk = 1'b0, conv_done = 1'b0;
   logic stack_full = 1'b0, sleep_mode = 1'b0, auto_ack = 1'b0;
   logic [1:0] tmr_match_a = 2'h0, tmr_match_p = 2'h0, lag = 2'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq_req, irq_ack, wake_pulse, er;
   logic pin_pullup_en, prescaler_clk;
   logic [7:0] irq_vector, last_vec;
   logic [3:0] sdiv = 4'h0; // Sub clock divider, 16 cycles a period
   logic [1:0] e;
   int fails = 0, n_tests = 0, cyc = 0, wakes = 0, pcnt = 0;
   logic [31:0] pv [5] = '{32'h4, 32'h5, 32'h6, 32'h7, 32'h3};
   int pw [5] = '{40, 40, 64, 64, 40};
   int pe [5] = '{40, 10, 4, 4, 0};

   mitp_top #(.TICK_CNT_W(16), .TB_BASE(1)) uut (
      .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
      .slow_clk(slow_clk), .tmr_match_a(tmr_match_a),
      .tmr_match_p(tmr_match_p), .conv_done(conv_done),
      .stack_full(stack_full), .irq_ack(irq_ack), .sleep_mode(sleep_mode),
      .irq_req(irq_req), .irq_vector(irq_vector), .wake_pulse(wake_pulse),
      .pin_pullup_en(pin_pullup_en), .prescaler_clk(prescaler_clk));

   mitp_core_model core (
      .core_clk(core_clk), .rst(rst), .irq_req(irq_req),
      .irq_vector(irq_vector), .auto_ack(auto_ack), .lag(lag),
      .irq_ack(irq_ack), .last_vec(last_vec));

   // ---------------------------------------------------------------
   // Clocks, monitors and timeout
   // ---------------------------------------------------------------
   always #5 core_clk = ~core_clk;
   // Counting at the falling edge keeps clear of update races
   always @(negedge core_clk) begin
      if (wake_pulse === 1'b1) wakes++;
      if (prescaler_clk === 1'b1) pcnt++;
   end
   always @(posedge core_clk) begin
      sdiv <= sdiv + 4'h1;
      slow_clk <= sdiv[3];
      cyc++;
      if (cyc == 20000) begin
         fails++;
         conclude();
      end
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task conclude();
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; pready is sampled at each rising edge of the
   // access phase, and read data is taken at the edge that sees it high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // A slave that never answers ends the run as a mismatch
      if (n >= 20) begin
         fails++;
         conclude();
      end
   endtask : apb
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdc
   task wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wt
   // One-cycle event pulses: conv, P[1:0], A[1:0]
   task ev(input logic [4:0] v);
      @(posedge core_clk);
      {conv_done, tmr_match_p, tmr_match_a} <= v;
      @(posedge core_clk);
      {conv_done, tmr_match_p, tmr_match_a} <= 5'h00;
   endtask : ev
   task pin(input logic v);
      @(posedge core_clk);
      ext_irq_pin <= v;
      wt(5);
   endtask : pin

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      wt(16);
      rst <= 1'b0;
      @(posedge core_clk);
      rdc(OFS_PSC_CTRL, 32'h0);
      rdc(OFS_IRQ_CTRL, 32'h0);
      apb(1'b0, 8'h1C, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, OFS_PSC_CTRL, 32'hFFFFFFFF);
      rdc(OFS_PSC_CTRL, 32'h7);
      $display("test registers done");
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, OFS_PSC_CTRL, pv[i]);
         wt(12);
         pcnt = 0;
         wt(pw[i]);
         chk(pcnt, pe[i]);
      end
      $display("test prescaler done");
      // Flag recorded while global enable is off; stack holds call
      apb(1'b1, OFS_IRQ_CTRL, 32'h40);
      ev(5'h10);
      wt(2);
      rdc(OFS_IRQ_FLAG, 32'h20);
      chk(irq_req, 32'h0);
      stack_full <= 1'b1;
      apb(1'b1, OFS_IRQ_CTRL, 32'h41);
      wt(3);
      chk(irq_req, 32'h0);
      stack_full <= 1'b0;
      wt(2);
      chk(irq_req, 32'h1);
      chk(irq_vector, 32'h1C);
      rdc(OFS_STATUS, 32'h0B);
      lag <= 2'h2;
      auto_ack <= 1'b1;
      wt(8);
      chk(last_vec, 32'h1C);
      rdc(OFS_IRQ_FLAG, 32'h0);
      rdc(OFS_IRQ_CTRL, 32'h40);
      $display("test converter done");
      for (int i = 0; i < 4; i++) begin
         e = i[1:0];
         apb(1'b1, OFS_IRQ_CTRL, {22'h0, e, 8'h82});
         pin(1'b1);
         chk(pin_pullup_en, 32'h1);
         rdc(OFS_IRQ_FLAG, {31'h0, e[0]});
         apb(1'b1, OFS_IRQ_FLAG, 32'h1);
         pin(1'b0);
         rdc(OFS_IRQ_FLAG, {31'h0, e[1]});
         apb(1'b1, OFS_IRQ_FLAG, 32'h1);
      end
      apb(1'b1, OFS_IRQ_CTRL, 32'h183);
      pin(1'b1);
      wt(6);
      chk(last_vec, 32'h04);
      rdc(OFS_IRQ_FLAG, 32'h0);
      rdc(OFS_IRQ_CTRL, 32'h182);
      $display("test external done");
      lag <= 2'h0;
      apb(1'b1, OFS_TMR_IRQ, 32'hA0);
      apb(1'b1, OFS_IRQ_CTRL, 32'h09);
      ev(5'h08);
      wt(4);
      chk(last_vec, 32'h0C);
      rdc(OFS_TMR_IRQ, 32'hA8);
      rdc(OFS_IRQ_FLAG, 32'h0);
      rdc(OFS_IRQ_CTRL, 32'h08);
      $display("test group done");
      // Three sources pending at once, taken one per re-enable
      auto_ack <= 1'b0;
      apb(1'b1, OFS_TMR_IRQ, 32'h1F);
      apb(1'b1, OFS_IRQ_CTRL, 32'h146);
      pin(1'b0);
      ev(5'h11);
      pin(1'b1);
      rdc(OFS_IRQ_FLAG, 32'h23);
      auto_ack <= 1'b1;
      apb(1'b1, OFS_IRQ_CTRL, 32'h147);
      wt(4);
      chk(last_vec, 32'h04);
      apb(1'b1, OFS_IRQ_CTRL, 32'h147);
      wt(4);
      chk(last_vec, 32'h08);
      apb(1'b1, OFS_IRQ_CTRL, 32'h147);
      wt(4);
      chk(last_vec, 32'h1C);
      $display("test priority done");
      // Ratio 2 with a quarter-rate step: overflow about 32 cycles on
      apb(1'b1, OFS_IRQ_FLAG, 32'h3F);
      apb(1'b1, OFS_PSC_CTRL, 32'h5);
      apb(1'b1, OFS_IRQ_CTRL, 32'h20);
      sleep_mode <= 1'b1;
      wakes = 0;
      apb(1'b1, OFS_TICK_CTRL1, 32'h82);
      wt(20);
      rdc(OFS_IRQ_FLAG, 32'h0);
      wt(25);
      rdc(OFS_IRQ_FLAG, 32'h10);
      chk(wakes, 32'h1);
      wt(40);
      chk(wakes, 32'h1);
      apb(1'b1, OFS_IRQ_CTRL, 32'h21);
      wt(4);
      chk(last_vec, 32'h14);
      sleep_mode <= 1'b0;
      // Shortest period on divider 0, taken through its own vector
      apb(1'b1, OFS_TICK_CTRL0, 32'h80);
      apb(1'b1, OFS_IRQ_CTRL, 32'h11);
      wt(40);
      chk(last_vec, 32'h10);
      $display("test tick done");
      conclude();
   end
endmodule : testbench
